// ---- sac_defines.svh ----
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SAC_OFS_RESULT 8'h00
`define SAC_OFS_MODE 8'h04
`define SAC_OFS_START 8'h08
`define SAC_OFS_EDGE 8'h0C
`define SAC_OFS_CTRL 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define SAC_MODE_TRG_BIT 6
`define SAC_START_FLAG_BIT 7
`define SAC_CTRL_EN_BIT 0
`define SAC_CTRL_PINFN_BIT 1
`define SAC_CTRL_IRQEN_BIT 2
`define SAC_CTRL_DONE_BIT 3
`define SAC_RES_LSB 6

// ----------------------------------------
// widths, reset values and read-back constants
// ----------------------------------------
`define SAC_RES_W 10
`define SAC_MODE_RST 7'h00
`define SAC_START_RSVD 8'h3F
`define SAC_CKS_DIV8 2'b00
`define SAC_CKS_DIV4 2'b01
`define SAC_CKS_DIV2 2'b10
`define SAC_CKS_SUB 2'b11
`define SAC_DIV8_LAST 3'h7
`define SAC_DIV4_LAST 3'h3
`define SAC_DIV2_LAST 3'h1
`define SAC_SAMPLE_TICKS 4'h5
`define SAC_CH_FIRST 4'h4
`define SAC_CH_LAST 4'h9

`endif

// ---- sac_pkg.sv ----
`default_nettype none
`include "sac_defines.svh"

package sac_pkg;

    // latched ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } sac_dph_s;

    // mode register fields, bit 7 is not stored
    typedef struct packed {
        logic trg_en;
        logic [1:0] cks;
        logic [3:0] ch;
    } sac_mode_s;

    // approximation engine states
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONV
    } sac_state_e;

    typedef logic [`SAC_RES_W-1:0] sac_res_t;

endpackage : sac_pkg

`default_nettype wire

// ---- sac_sar.sv ----
`default_nettype none
`include "sac_defines.svh"

module sac_sar (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic comp_in,
    output logic busy,
    output logic done,
    output logic sample_hold,
    output sac_pkg::sac_res_t dac_code,
    output sac_pkg::sac_res_t result
);
    import sac_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    sac_state_e state_q; // engine phase
    logic [3:0] cnt_q; // sample ticks, then bit index
    sac_res_t sar_q; // trial code
    sac_res_t res_q; // final result, no reset
    logic done_q; // one-cycle completion pulse
    logic res_ok_q; // a result has been stored since reset
    sac_res_t trial; // trial code after comparator decision

    // one-hot mask of a bit position
    function automatic sac_res_t bit_mask(input logic [3:0] idx);
        bit_mask = sac_res_t'(1) << idx;
    endfunction : bit_mask

    // drop the trial bit when the input sits below the ladder level
    assign trial = comp_in ? sar_q : (sar_q & ~bit_mask(cnt_q));

    // ----------------------------------------
    // sequencer: sample, then one bit per tick
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= SAC_IDLE;
            cnt_q <= 4'h0;
            sar_q <= '0;
        end else if (abort) begin
            // forced stop, nothing is stored
            state_q <= SAC_IDLE;
        end else begin
            unique case (state_q)
                SAC_IDLE: begin
                    if (start) begin
                        // hold the input before any step
                        state_q <= SAC_SAMPLE;
                        cnt_q <= 4'h0;
                    end
                end
                SAC_SAMPLE: begin
                    if (tick && cnt_q == `SAC_SAMPLE_TICKS - 4'h1) begin
                        state_q <= SAC_CONV;
                        cnt_q <= 4'(`SAC_RES_W - 1);
                        sar_q <= bit_mask(4'(`SAC_RES_W - 1));
                    end else if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                SAC_CONV: begin
                    // successive approximation, msb first
                    if (tick && cnt_q == 4'h0) begin
                        state_q <= SAC_IDLE;
                        sar_q <= trial;
                    end else if (tick) begin
                        sar_q <= trial | bit_mask(cnt_q - 4'h1);
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // result store, kept until the next completion
    // ----------------------------------------
    // no reset: contents are undefined until the first conversion
    always_ff @(posedge hclk) begin
        if (state_q == SAC_CONV && tick && cnt_q == 4'h0 && !abort) begin
            res_q <= trial;
        end
    end

    // completion pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == SAC_CONV) && tick && cnt_q == 4'h0 && !abort;
        end
    end

    // helper for the hold check: the result word is undefined until the first store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_ok_q <= 1'b0;
        end else if (done_q) begin
            res_ok_q <= 1'b1;
        end
    end

    assign busy = (state_q != SAC_IDLE);
    assign done = done_q;
    assign sample_hold = (state_q == SAC_SAMPLE);
    assign dac_code = sar_q;
    assign result = res_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // gated by a stored result, since an undefined word would fire falsely
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        res_ok_q && !busy && !start ##1 !busy |-> $stable(res_q);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while idle");

endmodule : sac_sar

`default_nettype wire

// ---- sac_ctrl.sv ----
// Chosen here: the address map and the AHB-Lite interface to the registers.
`default_nettype none
`include "sac_defines.svh"

module sac_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ext_trigger_pin,
    input wire logic subclock_in,
    input wire logic comp_in,
    output logic sample_hold,
    output sac_pkg::sac_res_t dac_code,
    output logic [2:0] analog_channel,
    output logic analog_channel_valid,
    output logic conversion_irq
);
    import sac_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    sac_dph_s dph_q; // pending data phase
    logic [31:0] hrdata_q; // read data captured in address phase
    sac_mode_s mode_q; // conversion_mode bits 6:0
    logic start_flag_q; // conversion_start_flag
    logic edge_sel_q; // trigger_edge_select, 1 = rising
    logic enable_q; // leaves module standby
    logic pin_fn_q; // trigger_pin_function_select
    logic irq_en_q; // conversion_irq_enable
    logic done_flag_q; // conversion_done_flag
    logic [2:0] trg_sync_q; // two-stage sync plus edge history
    logic [2:0] sub_sync_q; // subclock sync plus edge history
    logic sub_half_q; // subclock/2 phase
    logic [2:0] div_q; // system clock divider
    logic [2:0] chan_q; // registered channel number
    logic chan_ok_q; // registered channel valid
    logic addr_ph; // address phase accepted
    logic wr_start; // data-phase write to start register
    logic wr_ctrl; // data-phase write to control register
    logic trg_edge; // qualified trigger edge
    logic tick; // one conversion clock
    logic sar_start; // engine start pulse
    logic sar_abort; // engine forced stop
    logic sar_busy; // engine running
    logic sar_done; // engine completion pulse
    sac_res_t sar_result; // last stored result

    // channel decode: codes 4..9 map to inputs 0..5
    function automatic logic chan_valid(input logic [3:0] ch);
        chan_valid = (ch >= `SAC_CH_FIRST) && (ch <= `SAC_CH_LAST);
    endfunction : chan_valid

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    // zero wait states, always OKAY; hsize is not decoded, words only
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign addr_ph = hsel && htrans[1] && hready;
    assign wr_start = dph_q.valid && dph_q.write && dph_q.addr == `SAC_OFS_START;
    assign wr_ctrl = dph_q.valid && dph_q.write && dph_q.addr == `SAC_OFS_CTRL;

    // latch the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= '0;
        end else if (hready) begin
            dph_q <= '{valid: addr_ph, write: hwrite, addr: haddr[7:0]};
        end
    end

    // read data is registered so it stands from the data phase start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            unique case (haddr[7:0])
                // upper ten bits of a sixteen-bit word
                `SAC_OFS_RESULT: hrdata_q <= {16'h0000, sar_result, 6'h00};
                `SAC_OFS_MODE: hrdata_q <= {24'h00_0000, 1'b0, mode_q};
                `SAC_OFS_START: hrdata_q <= {24'h00_0000,
                    `SAC_START_RSVD | {start_flag_q, 7'h00}};
                `SAC_OFS_EDGE: hrdata_q <= {31'h0000_0000, edge_sel_q};
                `SAC_OFS_CTRL: hrdata_q <= {28'h000_0000, done_flag_q,
                    irq_en_q, pin_fn_q, enable_q};
                // unmapped offsets read as zero
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // software-written configuration
    // ----------------------------------------
    // mode register, bit 7 not stored so writes cannot reach it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= `SAC_MODE_RST;
        end else if (dph_q.valid && dph_q.write && dph_q.addr == `SAC_OFS_MODE) begin
            mode_q <= hwdata[6:0];
        end
    end

    // edge select register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_sel_q <= 1'b0;
        end else if (dph_q.valid && dph_q.write && dph_q.addr == `SAC_OFS_EDGE) begin
            edge_sel_q <= hwdata[0];
        end
    end

    // control: standby release, pin function, irq enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= 1'b0; // halted in standby out of reset
            pin_fn_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            enable_q <= hwdata[`SAC_CTRL_EN_BIT];
            pin_fn_q <= hwdata[`SAC_CTRL_PINFN_BIT];
            irq_en_q <= hwdata[`SAC_CTRL_IRQEN_BIT];
        end
    end

    // ----------------------------------------
    // external trigger
    // ----------------------------------------
    // two flops before any logic, third keeps the previous sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trg_sync_q <= 3'h0;
        end else begin
            trg_sync_q <= {trg_sync_q[1:0], ext_trigger_pin};
        end
    end

    // edge picked by select bit, gated by enable, pin function and the mode trigger enable
    assign trg_edge = enable_q && pin_fn_q && mode_q.trg_en
        && (edge_sel_q ? (trg_sync_q[1] && !trg_sync_q[2])
                       : (!trg_sync_q[1] && trg_sync_q[2]));

    // ----------------------------------------
    // start flag
    // ----------------------------------------
    // a start in the completion cycle wins over the self-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_flag_q <= 1'b0;
        end else if (!enable_q) begin
            start_flag_q <= 1'b0;
        end else if (trg_edge || (wr_start && hwdata[`SAC_START_FLAG_BIT])) begin
            start_flag_q <= 1'b1;
        end else if (sar_done || wr_start) begin
            start_flag_q <= 1'b0;
        end
    end

    assign sar_start = start_flag_q && !sar_busy && !sar_done;
    // a zero written mid-conversion aborts; standby also stops it
    assign sar_abort = !enable_q || (wr_start && !hwdata[`SAC_START_FLAG_BIT]);

    // ----------------------------------------
    // conversion clock
    // ----------------------------------------
    // subclock is a pin: synchronise, then count its rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_sync_q <= 3'h0;
            sub_half_q <= 1'b0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], subclock_in};
            if (sub_sync_q[1] && !sub_sync_q[2]) begin
                sub_half_q <= !sub_half_q;
            end
        end
    end

    // divider restarts while idle so every conversion on a system clock divider has equal length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 3'h0;
        end else if (!sar_busy || tick) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // fifteen ticks per conversion stay within 124, 62 and 31 states
    always_comb begin
        unique case (mode_q.cks)
            `SAC_CKS_DIV8: tick = (div_q == `SAC_DIV8_LAST);
            `SAC_CKS_DIV4: tick = (div_q == `SAC_DIV4_LAST);
            `SAC_CKS_DIV2: tick = (div_q == `SAC_DIV2_LAST);
            `SAC_CKS_SUB: tick = sub_sync_q[1] && !sub_sync_q[2] && sub_half_q;
        endcase
    end

    // ----------------------------------------
    // approximation engine
    // ----------------------------------------
    sac_sar u_sar (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .start(sar_start),
        .abort(sar_abort),
        .comp_in(comp_in),
        .busy(sar_busy),
        .done(sar_done),
        .sample_hold(sample_hold),
        .dac_code(dac_code),
        .result(sar_result)
    );

    // ----------------------------------------
    // done flag and interrupt request
    // ----------------------------------------
    // write 1 clears; a completion in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag_q <= 1'b0;
        end else if (sar_done) begin
            done_flag_q <= 1'b1;
        end else if (wr_ctrl && hwdata[`SAC_CTRL_DONE_BIT]) begin
            done_flag_q <= 1'b0;
        end
    end

    assign conversion_irq = done_flag_q && irq_en_q;

    // channel mux select, invalid codes select nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_q <= 3'h0;
            chan_ok_q <= 1'b0;
        end else begin
            chan_ok_q <= chan_valid(mode_q.ch);
            chan_q <= chan_valid(mode_q.ch) ? 3'(mode_q.ch - `SAC_CH_FIRST) : 3'h0;
        end
    end

    assign analog_channel = chan_q;
    assign analog_channel_valid = chan_ok_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_standby;
        @(posedge hclk) disable iff (!hresetn) !enable_q |=> !sar_busy && !start_flag_q;
    endproperty
    a_standby: assert property (p_standby) else $error("converter ran in standby");
    property p_self_clear;
        @(posedge hclk) disable iff (!hresetn)
        sar_done && !trg_edge && !wr_start |=> !start_flag_q && done_flag_q;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("flag not cleared");
    property p_irq;
        @(posedge hclk) disable iff (!hresetn) sar_done && irq_en_q |=> conversion_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no irq after completion");
    property p_trg_off;
        @(posedge hclk) disable iff (!hresetn)
        !mode_q.trg_en && !start_flag_q && !wr_start |=> !start_flag_q;
    endproperty
    a_trg_off: assert property (p_trg_off) else $error("disabled trigger started");
    property p_sample_first;
        @(posedge hclk) disable iff (!hresetn)
        sar_start && !sar_abort |=> sample_hold [*5];
    endproperty
    a_sample_first: assert property (p_sample_first) else $error("no sample phase");
    property p_abort;
        @(posedge hclk) disable iff (!hresetn)
        sar_busy && wr_start && !hwdata[7] |=> !sar_busy && !start_flag_q;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    property p_mode7;
        @(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr[7:0] == `SAC_OFS_MODE |=> hrdata[7] == 1'b0;
    endproperty
    a_mode7: assert property (p_mode7) else $error("mode bit 7 read as one");
    property p_res_just;
        @(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr[7:0] == `SAC_OFS_RESULT |=> hrdata[5:0] == 6'h00
            && hrdata[31:16] == 16'h0000;
    endproperty
    a_res_just: assert property (p_res_just) else $error("result not left-justified");
    property p_trg_start;
        @(posedge hclk) disable iff (!hresetn) trg_edge |=> start_flag_q;
    endproperty
    a_trg_start: assert property (p_trg_start) else $error("trigger edge lost");

    c_done: cover property (@(posedge hclk) disable iff (!hresetn) sar_done);
    c_trig: cover property (@(posedge hclk) disable iff (!hresetn) trg_edge && !sar_busy);
    c_abort: cover property (@(posedge hclk) disable iff (!hresetn) sar_busy && sar_abort);
    c_sub: cover property (@(posedge hclk) disable iff (!hresetn)
        sar_done && mode_q.cks == `SAC_CKS_SUB);

endmodule : sac_ctrl

`default_nettype wire

// ---- sac_analog_model.sv ----
`default_nettype none

// ----------------------------------------
// analog side: held input level and comparator
// ----------------------------------------
module sac_analog_model (
    input wire logic hclk,
    input wire logic sample_hold,
    input wire sac_pkg::sac_res_t dac_code,
    input wire logic [2:0] analog_channel,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;

    sac_res_t held_q; // level frozen when sampling ends

    // each channel carries its own level, so a wrong channel shows in the result
    always_ff @(posedge hclk) begin
        if (sample_hold) begin
            held_q <= {analog_channel, 7'h2B};
        end
    end

    // comparator: high while the held level reaches the trial code
    assign comp_in = (held_q >= dac_code);
endmodule : sac_analog_model

`default_nettype wire

// ---- tb_sar_adc_control.sv ----
`default_nettype none
`include "sac_defines.svh"

module tb_sar_adc_control;
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;

    // ----------------------------------------
    // bus, pins and bookkeeping
    // ----------------------------------------
    logic hclk, hresetn, hsel, hwrite, hready, trig, sub_clk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, achan;
    logic hreadyout, hresp, comp_in, sample_hold, achan_ok, irq;
    sac_res_t dac_code;
    int fails, num_checks, cyc, t0, el;

    assign hready = hreadyout; // single slave drives the bus ready

    sac_ctrl sac_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_trigger_pin(trig),
        .subclock_in(sub_clk), .comp_in(comp_in), .sample_hold(sample_hold),
        .dac_code(dac_code), .analog_channel(achan), .analog_channel_valid(achan_ok),
        .conversion_irq(irq));

    sac_analog_model sac_analog_model_inst (.hclk(hclk), .sample_hold(sample_hold),
        .dac_code(dac_code), .analog_channel(achan), .comp_in(comp_in));

    // clocks: subclock period unrelated to the bus clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        sub_clk = 1'b0;
        forever #75 sub_clk = ~sub_clk;
    end

    // hang guard, well above the length of the sequence
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc > 40000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task finish_test;
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // ----------------------------------------
    // ahb-lite single word transfers
    // ----------------------------------------
    task xfer(input logic wr_n_rd, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr_n_rd;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata; // read data taken at the data phase edge
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdc

    // poll the start flag until the engine is idle, bounded
    task wait_idle;
        int n;
        n = 0;
        xfer(1'b0, `SAC_OFS_START, 32'h0000_0000);
        while (rd[7] !== 1'b0 && n < 600) begin
            xfer(1'b0, `SAC_OFS_START, 32'h0000_0000);
            n = n + 1;
        end
        el = cyc - t0;
        chk("idle", 32'h0, rd[7]);
    endtask : wait_idle

    task conv(input logic [6:0] mode, input logic [31:0] ctrl);
        // bit 3 clears the done flag left by the previous conversion
        wr(`SAC_OFS_CTRL, ctrl | 32'h0000_0008);
        wr(`SAC_OFS_MODE, {25'h0, mode});
        wr(`SAC_OFS_START, 32'h0000_0080);
        t0 = cyc;
        wait_idle();
    endtask : conv

    // expected word: level of analog channel c, left-justified
    function automatic logic [31:0] res_word(input logic [2:0] c);
        return {16'h0000, c, 7'h2B, 6'h00};
    endfunction : res_word

    initial begin
        int dv;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        trig = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("irq_rst", 32'h0, irq);
        chk("hresp", 32'h0, hresp);
        rdc("mode_rst", `SAC_OFS_MODE, 32'h0000_0000);
        rdc("ctrl_rst", `SAC_OFS_CTRL, 32'h0000_0000);
        wr(`SAC_OFS_START, 32'h0000_0080);
        rdc("standby", `SAC_OFS_START, 32'h0000_003F);
        wr(`SAC_OFS_MODE, 32'h0000_00FF);
        rdc("mode_b7", `SAC_OFS_MODE, 32'h0000_007F);
        chk("no_chan", 32'h0, achan_ok);
        rdc("unmapped", 8'h14, 32'h0000_0000);
        // every channel, rotating through the three bus clock dividers
        for (int i = 0; i < 6; i++) begin
            dv = 8 >> (i % 3);
            conv({1'b0, 2'(i % 3), 4'(4 + i)}, 32'h0000_0005);
            rdc("result", `SAC_OFS_RESULT, res_word(3'(i)));
            chk("chan", {29'h0, 3'(i)}, achan);
            chk("chan_ok", 32'h1, achan_ok);
            chk("time", 32'h1, (el >= 15 * dv && el <= 16 * dv + 8));
            rdc("done", `SAC_OFS_CTRL, 32'h0000_000D);
            chk("irq", 32'h1, irq);
        end
        // subclock divider with the request masked
        conv(7'h39, 32'h0000_0001);
        rdc("sub_res", `SAC_OFS_RESULT, res_word(3'd5));
        rdc("masked", `SAC_OFS_CTRL, 32'h0000_0009);
        chk("irq_off", 32'h0, irq);
        wr(`SAC_OFS_CTRL, 32'h0000_0009);
        rdc("clr", `SAC_OFS_CTRL, 32'h0000_0001);
        wr(`SAC_OFS_MODE, 32'h0000_0004);
        rdc("hold", `SAC_OFS_RESULT, res_word(3'd5));
        // abort inside the bit steps: no store, no done
        conv(7'h05, 32'h0000_0005);
        wr(`SAC_OFS_MODE, 32'h0000_0004);
        wr(`SAC_OFS_CTRL, 32'h0000_000D);
        wr(`SAC_OFS_START, 32'h0000_0080);
        repeat (60) @(posedge hclk);
        wr(`SAC_OFS_START, 32'h0000_0000);
        rdc("abort", `SAC_OFS_START, 32'h0000_003F);
        repeat (200) @(posedge hclk);
        rdc("ab_done", `SAC_OFS_CTRL, 32'h0000_0005);
        rdc("ab_hold", `SAC_OFS_RESULT, res_word(3'd1));
        // trigger pin: rising edge selected
        wr(`SAC_OFS_CTRL, 32'h0000_0007);
        wr(`SAC_OFS_EDGE, 32'h0000_0001);
        wr(`SAC_OFS_MODE, 32'h0000_0066);
        trig <= 1'b1;
        repeat (6) @(posedge hclk);
        wait_idle();
        rdc("trg_r", `SAC_OFS_RESULT, res_word(3'd2));
        trig <= 1'b0;
        repeat (8) @(posedge hclk);
        rdc("trg_f_no", `SAC_OFS_START, 32'h0000_003F);
        // falling edge selected
        wr(`SAC_OFS_EDGE, 32'h0000_0000);
        wr(`SAC_OFS_MODE, 32'h0000_0067);
        trig <= 1'b1;
        repeat (8) @(posedge hclk);
        rdc("trg_r_no", `SAC_OFS_START, 32'h0000_003F);
        trig <= 1'b0;
        repeat (6) @(posedge hclk);
        wait_idle();
        rdc("trg_f", `SAC_OFS_RESULT, res_word(3'd3));
        // trigger enable off in the mode register
        wr(`SAC_OFS_MODE, 32'h0000_0028);
        trig <= 1'b1;
        repeat (8) @(posedge hclk);
        trig <= 1'b0;
        repeat (8) @(posedge hclk);
        rdc("trg_off", `SAC_OFS_START, 32'h0000_003F);
        rdc("trg_hold", `SAC_OFS_RESULT, res_word(3'd3));
        finish_test();
    end
endmodule : tb_sar_adc_control

`default_nettype wire
